// [adc_link_pkg.sv]
// constants, carriers and states shared by the dual channel serial output logic
// assumes results arrive as 12-bit two's-complement words on the system clock
package adc_link_pkg;

  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int RESULT_WIDTH = 12;
  localparam int NULL_BITS = 4;
  localparam int WORD_BITS = 16;
  localparam int FRAME_BITS = 32;
  localparam int SHIFT_A_WIDTH = 28;
  localparam logic [3:0] NULL_FIELD = 4'h0;

  // ----------------------------------------------------------------
  // bit positions counted in falling serial clock edges since frame start
  // ----------------------------------------------------------------
  localparam logic [5:0] INDEX_RESET = 6'h00;
  localparam logic [5:0] INDEX_STEP = 6'h01;
  localparam logic [5:0] LOAD_INDEX = 6'h04;
  localparam logic [5:0] WORD_END_INDEX = 6'h10;
  localparam logic [5:0] FRAME_END_INDEX = 6'h20;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam logic CS_N_RESET = 1'b1;
  localparam logic DUAL_RESET = 1'b0;

  // ----------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] a;
    logic [11:0] b;
  } sample_pair_type;

  typedef struct packed {
    logic dual;
    sample_pair_type pair;
  } frame_hold_type;

  typedef enum logic [1:0] {
    POWER_DOWN,
    CONVERTING
  } sys_state_type;

endpackage

// [level_sync.sv]
// two flip-flop synchroniser for levels entering a clock domain
// assumes the input is a level that stays put for several destination clocks
`timescale 1ns/1ps

module level_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // the first stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= RESET_VALUE;
      q <= RESET_VALUE;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// [dual_channel_adc_serial_output.sv]
// conversion control and serial output of a dual, simultaneously sampling converter
// assumes results come from the front end on clk_sys; sclk and cs_n from the serial master
//
// Operation
// - both channel results are captured into one register in the same cycle for each frame.
// - each result is sent as a 12-bit two's-complement word.
// - with the split select high, channel A goes out on serial_out_a and channel B on serial_out_b.
// - with the split select low, channel A then channel B go out on serial_out_a.
// - with the split select low, serial_out_b is never driven.
// - one serial clock and one chip select serve both channels together.
// - each channel word is four zero bits then twelve result bits, most significant first.
// - output bits change on falling serial clock edges for sampling on the next rising edge.
// - a falling chip select starts a conversion; high chip select means power-down.
// - bit timing of the conversion is paced only by the serial clock.
`timescale 1ns/1ps

module dual_channel_adc_serial_output (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic dual_select,
  input adc_link_pkg::sample_pair_type samples,
  output logic conversion_start,
  output logic power_down,
  output logic serial_out_a,
  output logic serial_out_a_oe,
  output logic serial_out_b,
  output logic serial_out_b_oe
);

  // ----------------------------------------------------------------
  // system domain: pin synchronisers
  // ----------------------------------------------------------------
  logic cs_n_sync;
  logic dual_sync;
  logic cs_n_prev_reg;
  logic cs_fall;

  level_sync #(
    .WIDTH(1),
    .RESET_VALUE(adc_link_pkg::CS_N_RESET)
  ) u_cs_sync (
    .clk(clk_sys),
    .reset_n(reset_n),
    .d(cs_n),
    .q(cs_n_sync)
  );

  level_sync #(
    .WIDTH(1),
    .RESET_VALUE(adc_link_pkg::DUAL_RESET)
  ) u_dual_sync (
    .clk(clk_sys),
    .reset_n(reset_n),
    .d(dual_select),
    .q(dual_sync)
  );

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cs_n_prev_reg <= adc_link_pkg::CS_N_RESET;
    end else begin
      cs_n_prev_reg <= cs_n_sync;
    end
  end

  assign cs_fall = cs_n_prev_reg & ~cs_n_sync;

  // ----------------------------------------------------------------
  // system domain: conversion state and simultaneous capture
  // ----------------------------------------------------------------
  adc_link_pkg::sys_state_type state_reg;
  adc_link_pkg::sys_state_type state_next;
  adc_link_pkg::frame_hold_type hold_reg;
  logic capture_toggle_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      adc_link_pkg::POWER_DOWN: begin
        if (cs_fall) begin
          state_next = adc_link_pkg::CONVERTING;
        end
      end
      adc_link_pkg::CONVERTING: begin
        if (cs_n_sync) begin
          state_next = adc_link_pkg::POWER_DOWN;
        end
      end
      default: begin
        state_next = adc_link_pkg::POWER_DOWN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= adc_link_pkg::POWER_DOWN;
    end else begin
      state_reg <= state_next;
    end
  end

  logic capture_now;

  assign capture_now = (state_reg == adc_link_pkg::POWER_DOWN) && cs_fall;

  // both channels and the mode are latched by one edge, so one frame shares one instant
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hold_reg <= '0;
    end else if (capture_now) begin
      hold_reg.pair <= samples;
      hold_reg.dual <= dual_sync;
    end
  end

  // a capture crosses as a change of level, not a pulse, because sclk
  // may be stopped when the pulse would have to be seen
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      capture_toggle_reg <= 1'b0;
    end else if (capture_now) begin
      capture_toggle_reg <= ~capture_toggle_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      conversion_start <= 1'b0;
    end else begin
      conversion_start <= capture_now;
    end
  end

  // follows this cycle's decision, so it drops on the same clk_sys edge that raises conversion_start
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      power_down <= 1'b1;
    end else begin
      power_down <= (state_next == adc_link_pkg::POWER_DOWN);
    end
  end

  // ----------------------------------------------------------------
  // link domain: capture event crossing
  // ----------------------------------------------------------------
  // the toggle settles well inside the four null bits, so the held word
  // is stable before the load edge; sclk only runs inside frames
  logic capture_toggle_sync;
  logic toggle_seen_reg;
  logic fresh;

  level_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'b0)
  ) u_toggle_sync (
    .clk(sclk),
    .reset_n(reset_n),
    .d(capture_toggle_reg),
    .q(capture_toggle_sync)
  );

  assign fresh = capture_toggle_sync ^ toggle_seen_reg;

  // ----------------------------------------------------------------
  // link domain: bit counter and shifters
  // ----------------------------------------------------------------
  logic frame_rst_n;
  logic [5:0] bit_index_reg;
  logic [5:0] bit_index_next;
  logic [27:0] shift_a_reg;
  logic [11:0] shift_b_reg;
  logic frame_dual_reg;
  logic out_a_reg;
  logic out_b_reg;

  // a high chip select ends the frame on its own, with no further sclk edge needed
  assign frame_rst_n = reset_n & ~cs_n;
  assign bit_index_next = bit_index_reg + adc_link_pkg::INDEX_STEP;

  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_index_reg <= adc_link_pkg::INDEX_RESET;
    end else if (bit_index_reg != adc_link_pkg::FRAME_END_INDEX) begin
      bit_index_reg <= bit_index_next;
    end
  end

  always_ff @(negedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      toggle_seen_reg <= 1'b0;
    end else if (bit_index_next == adc_link_pkg::LOAD_INDEX) begin
      toggle_seen_reg <= capture_toggle_sync;
    end
  end

  // edge decodes shared by the output registers; the end of frame wins over all else
  logic frame_done;
  logic load_edge;
  logic shift_edge;
  logic word_done;

  assign frame_done = (bit_index_reg == adc_link_pkg::FRAME_END_INDEX);
  assign load_edge = ~frame_done && (bit_index_next == adc_link_pkg::LOAD_INDEX);
  assign shift_edge = ~frame_done && (bit_index_next > adc_link_pkg::LOAD_INDEX);
  assign word_done = (bit_index_next >= adc_link_pkg::WORD_END_INDEX);

  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      frame_dual_reg <= adc_link_pkg::DUAL_RESET;
    end else if (load_edge) begin
      frame_dual_reg <= hold_reg.dual;
    end
  end

  // A word, four nulls, then B word: the single output frame
  // a missed capture gives zeros rather than a stale word
  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      shift_a_reg <= '0;
    end else if (load_edge) begin
      if (fresh) begin
        shift_a_reg <= {hold_reg.pair.a[10:0], adc_link_pkg::NULL_FIELD,
                        hold_reg.pair.b, 1'b0};
      end else begin
        shift_a_reg <= '0;
      end
    end else if (shift_edge) begin
      shift_a_reg <= {shift_a_reg[26:0], 1'b0};
    end
  end

  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      shift_b_reg <= '0;
    end else if (load_edge) begin
      if (fresh) begin
        shift_b_reg <= {hold_reg.pair.b[10:0], 1'b0};
      end else begin
        shift_b_reg <= '0;
      end
    end else if (shift_edge) begin
      shift_b_reg <= {shift_b_reg[10:0], 1'b0};
    end
  end

  // outputs change only on falling edges; before the load edge they carry null zeros
  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      out_a_reg <= 1'b0;
    end else if (frame_done) begin
      out_a_reg <= 1'b0;
    end else if (load_edge) begin
      if (fresh) begin
        out_a_reg <= hold_reg.pair.a[11];
      end else begin
        out_a_reg <= adc_link_pkg::RESULT_RESET[11];
      end
    end else if (shift_edge) begin
      // in split mode each output stops after its own sixteen bits
      if (frame_dual_reg && word_done) begin
        out_a_reg <= 1'b0;
      end else begin
        out_a_reg <= shift_a_reg[27];
      end
    end
  end

  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      out_b_reg <= 1'b0;
    end else if (frame_done) begin
      out_b_reg <= 1'b0;
    end else if (load_edge) begin
      if (fresh) begin
        out_b_reg <= hold_reg.pair.b[11];
      end else begin
        out_b_reg <= adc_link_pkg::RESULT_RESET[11];
      end
    end else if (shift_edge) begin
      if (word_done) begin
        out_b_reg <= 1'b0;
      end else begin
        out_b_reg <= shift_b_reg[11];
      end
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // one select and one clock drive both outputs
  assign serial_out_a = out_a_reg;
  assign serial_out_b = out_b_reg;
  assign serial_out_a_oe = ~cs_n;
  // the enable follows the synchronised strap, not the captured mode, so lowering the strap inside a frame floats the pin two clk_sys cycles later
  assign serial_out_b_oe = ~cs_n & dual_sync;

endmodule

// [adc_link_asserts.sv]
// checker for the dual channel serial output block, bound to its ports
// assumes sclk idles low between frames and cs_n resets the link side
`timescale 1ns/1ps
module adc_link_asserts (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic dual_select,
  input wire logic conversion_start,
  input wire logic power_down,
  input wire logic serial_out_a,
  input wire logic serial_out_a_oe,
  input wire logic serial_out_b,
  input wire logic serial_out_b_oe
);
  logic [5:0] bit_reg;
  // bit index being sampled by the master at each rising sclk
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_reg <= 6'h00;
    end else begin
      bit_reg <= bit_reg + 6'h01;
    end
  end
  pd_high_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cs_n [*4] |-> power_down) else $error("power down missing");
  start_fall_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(cs_n) |-> ##[1:5] conversion_start) else $error("no capture");
  start_cause_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    conversion_start |=> !conversion_start ##0 !$past(cs_n, 3)) else $error("bad capture");
  oe_a_match_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    serial_out_a_oe == !cs_n) else $error("oe a wrong");
  oe_b_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!dual_select) [*3] |-> !serial_out_b_oe) else $error("oe b driven");
  oe_b_on_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (dual_select && !cs_n) [*3] |-> serial_out_b_oe) else $error("oe b idle");
  hold_high_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sclk && $past(sclk) && !cs_n && !$past(cs_n) |-> $stable(serial_out_a)
    && $stable(serial_out_b)) else $error("bit moved on high sclk");
  null_bits_a: assert property (@(posedge sclk) disable iff (!reset_n || cs_n)
    bit_reg < 6'h04 |-> !serial_out_a && (!serial_out_b || !serial_out_b_oe))
    else $error("null bits wrong");
  word_gap_a: assert property (@(posedge sclk) disable iff (!reset_n || cs_n)
    bit_reg inside {[6'h10:6'h13]} |-> !serial_out_a) else $error("gap not zero");
  cover property (@(posedge clk_sys) conversion_start);
  cover property (@(posedge clk_sys) serial_out_b_oe);
  cover property (@(posedge sclk) bit_reg == 6'h1F);
endmodule

bind dual_channel_adc_serial_output adc_link_asserts adc_link_asserts_inst (.clk_sys, .reset_n,
  .sclk, .cs_n, .dual_select, .conversion_start, .power_down, .serial_out_a, .serial_out_a_oe,
  .serial_out_b, .serial_out_b_oe);

// [serial_master_model.sv]
// serial master model: 32-clock frames, samples both outputs on rising sclk
// assumes go is raised by the bench only while busy is low
`timescale 1ns/1ps
module serial_master_model (
  input wire logic go,
  input wire logic serial_out_a,
  input wire logic serial_out_a_oe,
  input wire logic serial_out_b,
  input wire logic serial_out_b_oe,
  output logic sclk,
  output logic cs_n,
  output logic busy,
  output logic [31:0] word_a,
  output logic [31:0] word_b
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    busy = 1'b0;
  end
  always @(posedge go) begin
    busy = 1'b1;
    // a random lead keeps the sclk edges at a varying phase to clk_sys
    #(($urandom % 6) + 1.5) cs_n = 1'b0;
    repeat (32) begin
      #32 sclk = 1'b1;
      // a floating pin reads unknown so it can never match
      word_a = {word_a[30:0], serial_out_a_oe ? serial_out_a : 1'bx};
      word_b = {word_b[30:0], serial_out_b_oe ? serial_out_b : 1'bx};
      #32 sclk = 1'b0;
    end
    #32 cs_n = 1'b1;
    busy = 1'b0;
  end
endmodule

// [dual_channel_adc_serial_output_tb_top.sv]
// self-checking bench: frames in both output modes, boundary and random results
// assumes the master model drives the link and the checker is bound to the design
`timescale 1ns/1ps
module dual_channel_adc_serial_output_tb_top;
  `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("Error %0t: got %h expected %h", $time, g, e); end end
  typedef struct packed {
    logic dual;
    logic [31:0] a;
    logic [31:0] b;
  } note_type;
  note_type notes[$];
  note_type exp_note;
  int err_total = 0;
  int comparisons = 0;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic dual_select = 1'b0;
  adc_link_pkg::sample_pair_type samples = '0;
  logic go = 1'b0;
  logic sclk, cs_n, busy, conversion_start, power_down;
  logic serial_out_a, serial_out_a_oe, serial_out_b, serial_out_b_oe;
  logic [31:0] word_a, word_b;
  always #4 clk_sys = ~clk_sys;
  dual_channel_adc_serial_output dual_channel_adc_serial_output_inst (.clk_sys, .reset_n,
    .sclk, .cs_n, .dual_select, .samples, .conversion_start, .power_down, .serial_out_a,
    .serial_out_a_oe, .serial_out_b, .serial_out_b_oe);
  serial_master_model serial_master_model_inst (.go, .serial_out_a, .serial_out_a_oe,
    .serial_out_b, .serial_out_b_oe, .sclk, .cs_n, .busy, .word_a, .word_b);
  task automatic close_out();
    if (err_total == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic bound(input int n);
    if (n >= 600) begin
      err_total++;
      close_out();
    end
  endtask
  task automatic frame(input logic d, input logic [23:0] s);
    int n;
    @(negedge clk_sys);
    dual_select = d;
    samples = s;
    notes.push_back(d ? {d, 4'h0, s[23:12], 20'h00000, s[11:0], 16'h0000}
      : {d, 4'h0, s[23:12], 4'h0, s[11:0], 32'h00000000});
    // the mode strap needs time to cross before the frame
    repeat (4) @(negedge clk_sys);
    go = 1'b1;
    for (n = 0; n < 600 && !conversion_start; n++) @(negedge clk_sys);
    bound(n);
    go = 1'b0;
    // both results are latched now, so new values must not reach the wire
    samples = ~s;
    for (n = 0; n < 600 && busy; n++) @(negedge clk_sys);
    bound(n);
    // short idle gap keeps the frame rate as high as the link clock allows
    repeat (6) @(negedge clk_sys);
  endtask
  always @(negedge busy) begin
    if (reset_n) begin
      exp_note = notes.pop_front();
      `CHK(word_a, exp_note.a)
      if (exp_note.dual) `CHK(word_b, exp_note.b)
    end
  end
  initial begin
    void'($urandom(32'h6BAA));
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    frame(1'b0, 24'h8007FF);
    frame(1'b1, 24'h7FF800);
    for (int i = 0; i < 16; i++) frame(i[0], 24'($urandom()));
    // second reset between frames, link must come back clean
    reset_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    frame(1'b1, 24'hFFF001);
    close_out();
  end
endmodule
